// >>> ehci_list_pointer_and_routing_regs.v
/*
  Operational register slice: periodic frame list base, asynchronous list
  pointer and port routing configuration, with wide address forming.
  Assumes a host register port that gives a byte offset with one-cycle
  read and write strobes, all inputs synchronous to SYS_CLK_I, a
  synchronous active high reset, and an upper segment selector value and
  wide addressing capability bit that come from elsewhere in the
  controller and stay steady while the pointers are in use.
*/
`timescale 1ns/1ns
`include "ehci_list_regs_defs.vh"
module ehci_list_pointer_and_routing_regs
(
  input wire SYS_CLK_I,
  input wire SRST_I,
  input wire [7:0] REG_ADDR_I,
  input wire REG_WR_I,
  input wire REG_RD_I,
  input wire [31:0] REG_WDATA_I,
  output wire [31:0] REG_RDATA_O,
  input wire [31:0] CAPABILITY_PARAMETERS_I,
  input wire [31:0] UPPER_SEGMENT_SELECTOR_I,
  output wire [63:0] PERIODIC_LIST_ADDR_O,
  output wire [63:0] ASYNC_QH_ADDR_O,
  output wire [1:0] PORT_ROUTE_HERE_O,
  output wire [1:0] PORT_ROUTE_COMPANION_O
);

  // ************************************
  // implemented bits and port count
  // ************************************
  // masks follow the field positions, so a moved field moves its mask
  localparam [31:0] periodic_mask =
    32'hFFFFFFFF << `PERIODIC_BA_LSB;

  localparam [31:0] async_mask =
    32'hFFFFFFFF << `ASYNC_LINK_LSB;
  localparam [31:0] routing_mask =
    32'h00000001 << `ROUTE_ALL_BIT;

  localparam integer port_count = `NUM_ROOT_PORTS;

  // ************************************
  // offset decode
  // ************************************
  wire hit_periodic;
  wire hit_async;
  wire hit_routing;

  assign hit_periodic = (REG_ADDR_I == `PERIODIC_BASE_OFFSET);
  assign hit_async = (REG_ADDR_I == `ASYNC_PTR_OFFSET);
  assign hit_routing = (REG_ADDR_I == `ROUTING_CFG_OFFSET);

  // ************************************
  // write strobes
  // ************************************
  // an unmapped offset matches no strobe, so its write is lost
  wire we_periodic;
  wire we_async;
  wire we_routing;
  wire [31:0] periodic_base;
  wire [31:0] async_list_pointer;
  wire [31:0] port_routing_config;

  assign we_periodic = REG_WR_I & hit_periodic;
  assign we_async = REG_WR_I & hit_async;
  assign we_routing = REG_WR_I & hit_routing;

  // ************************************
  // periodic frame list base
  // ************************************
  // reserved bits are dropped on write, so a careless driver cannot set them
  field_reg
  #(
    .MASK(periodic_mask),
    .RESET_VALUE(`PERIODIC_BASE_RESET)
  )
  periodic_frame_list_base
  (
    .clk_i(SYS_CLK_I),
    .srst_i(SRST_I),
    .we_i(we_periodic),
    .wdata_i(REG_WDATA_I),
    .q_o(periodic_base)
  );

  // ************************************
  // asynchronous list pointer
  // ************************************
  field_reg
  #(
    .MASK(async_mask),
    .RESET_VALUE(`ASYNC_PTR_RESET)
  )
  async_list_pointer_reg
  (
    .clk_i(SYS_CLK_I),
    .srst_i(SRST_I),
    .we_i(we_async),
    .wdata_i(REG_WDATA_I),
    .q_o(async_list_pointer)
  );

  // ************************************
  // port routing config
  // ************************************
  field_reg
  #(
    .MASK(routing_mask),
    .RESET_VALUE(`ROUTING_CFG_RESET)
  )
  port_routing_config_reg
  (
    .clk_i(SYS_CLK_I),
    .srst_i(SRST_I),
    .we_i(we_routing),
    .wdata_i(REG_WDATA_I),
    .q_o(port_routing_config)
  );

  // ************************************
  // read select
  // ************************************
  // unmapped offsets read zero; the async tail is masked again on the way out
  reg [31:0] read_select;

  always @*
  begin
    read_select = 32'h00000000;
    if (hit_periodic)
      read_select = periodic_base;
    if (hit_async)
      read_select = async_list_pointer & async_mask;
    if (hit_routing)
      read_select = port_routing_config;
  end

  // ************************************
  // read data
  // ************************************
  // held between reads; a read beside a write returns the older value
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;

  always @*
  begin
    rdata_next = rdata_reg;
    if (REG_RD_I)
      rdata_next = read_select;
  end

  always @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
      rdata_reg <= 32'h00000000;
    else
      rdata_reg <= rdata_next;
  end

  assign REG_RDATA_O = rdata_reg;

  // ************************************
  // upper address word
  // ************************************
  wire wide_addressing_capability;
  wire [31:0] upper_word;

  assign wide_addressing_capability =
    CAPABILITY_PARAMETERS_I[`WIDE_ADDR_BIT];

  // the upper word is not latched, so it must not change under a live list
  assign upper_word = wide_addressing_capability ?
    UPPER_SEGMENT_SELECTOR_I : 32'h00000000;

  // ************************************
  // address words
  // ************************************
  // the low words carry the pointer fields; the zero tail gives alignment
  wire [31:0] periodic_addr_low;
  wire [31:0] async_addr_low;

  assign periodic_addr_low = periodic_base & periodic_mask;
  assign async_addr_low = async_list_pointer & async_mask;
  assign PERIODIC_LIST_ADDR_O = {upper_word, periodic_addr_low};
  assign ASYNC_QH_ADDR_O = {upper_word, async_addr_low};

  // ************************************
  // port routing
  // ************************************
  // no hold-off: routing follows the flag from the clock after the write
  wire route_all_ports_flag;
  wire [port_count-1:0] route_here;
  wire [port_count-1:0] route_companion;
  genvar p;

  assign route_all_ports_flag = port_routing_config[`ROUTE_ALL_BIT];

  generate
    for (p = 0; p < port_count; p = p + 1)
    begin : port_route
      assign route_here[p] = route_all_ports_flag;
      assign route_companion[p] = ~route_all_ports_flag;
    end
  endgenerate

  assign PORT_ROUTE_HERE_O = route_here;
  assign PORT_ROUTE_COMPANION_O = route_companion;

endmodule

// >>> ehci_list_regs_defs.vh
/*
  Register offsets, field positions and reset values for the list pointer
  and port routing register slice.
  Assumes inclusion by bare name from the design files.
*/
`ifndef EHCI_LIST_REGS_DEFS_VH
`define EHCI_LIST_REGS_DEFS_VH

// ************************************
// offsets from the memory base address
// ************************************
`define PERIODIC_BASE_OFFSET 8'h34
`define ASYNC_PTR_OFFSET 8'h38
`define ROUTING_CFG_OFFSET 8'h60

// ************************************
// field positions
// ************************************
`define PERIODIC_BA_MSB 31
`define PERIODIC_BA_LSB 12
`define ASYNC_LINK_MSB 31
`define ASYNC_LINK_LSB 5
`define ROUTE_ALL_BIT 0
`define WIDE_ADDR_BIT 0

// ************************************
// reset values and root port count
// ************************************
`define PERIODIC_BASE_RESET 32'h00000000
`define ASYNC_PTR_RESET 32'h00000000
`define ROUTING_CFG_RESET 32'h00000000
`define NUM_ROOT_PORTS 2

`endif

// >>> field_reg.v
/*
  One writable register with a fixed mask of implemented bits.
  Assumes a synchronous active high reset and a one-cycle write strobe.
*/
`timescale 1ns/1ns
module field_reg
#(
  parameter [31:0] MASK = 32'hFFFFFFFF,
  parameter [31:0] RESET_VALUE = 32'h00000000
)
(
  input wire clk_i,
  input wire srst_i,
  input wire we_i,
  input wire [31:0] wdata_i,
  output wire [31:0] q_o
);
  reg [31:0] value_reg;
  wire [31:0] value_next;

  // unimplemented bits never store, so they always read zero
  assign value_next = we_i ? (wdata_i & MASK) : value_reg;

  always @(posedge clk_i)
  begin
    if (srst_i)
      value_reg <= RESET_VALUE & MASK;
    else
      value_reg <= value_next;
  end

  assign q_o = value_reg;
endmodule

// >>> list_regs_sva.sv
/* checker for the list pointer and routing registers
   assumes a bind onto the register slice top */
`timescale 1ns/1ns
module list_regs_sva
(
  input wire SYS_CLK_I,
  input wire SRST_I,
  input wire [7:0] REG_ADDR_I,
  input wire REG_WR_I,
  input wire REG_RD_I,
  input wire [31:0] REG_WDATA_I,
  input wire [31:0] REG_RDATA_O,
  input wire [31:0] CAPABILITY_PARAMETERS_I,
  input wire [31:0] UPPER_SEGMENT_SELECTOR_I,
  input wire [63:0] PERIODIC_LIST_ADDR_O,
  input wire [63:0] ASYNC_QH_ADDR_O,
  input wire [1:0] PORT_ROUTE_HERE_O,
  input wire [1:0] PORT_ROUTE_COMPANION_O
);
  // ************************************
  // rules
  // ************************************
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (SRST_I);
  wire [31:0] up = CAPABILITY_PARAMETERS_I[0] ? UPPER_SEGMENT_SELECTOR_I :
    32'h00000000;
  base_low_a: assert property (PERIODIC_LIST_ADDR_O[11:0] == 12'h000)
    else $error("base low bits set");
  base_write_a: assert property (REG_WR_I && REG_ADDR_I == 8'h34 |=>
    PERIODIC_LIST_ADDR_O[31:12] == $past(REG_WDATA_I[31:12]))
    else $error("base write lost");
  async_write_a: assert property (REG_WR_I && REG_ADDR_I == 8'h38
    |=> ASYNC_QH_ADDR_O[31:5] == $past(REG_WDATA_I[31:5]))
    else $error("async write lost");
  async_low_a: assert property (ASYNC_QH_ADDR_O[4:0] == 5'h00)
    else $error("async low bits set");
  async_read_a: assert property (REG_RD_I && REG_ADDR_I == 8'h38
    |=> REG_RDATA_O == $past(ASYNC_QH_ADDR_O[31:0]))
    else $error("async read");
  upper_word_a: assert property (ASYNC_QH_ADDR_O[63:32] == up &&
    PERIODIC_LIST_ADDR_O[63:32] == up) else $error("upper word");
  route_split_a: assert property (PORT_ROUTE_COMPANION_O ==
    ~PORT_ROUTE_HERE_O) else $error("routing split");
  flag_write_a: assert property (REG_WR_I && REG_ADDR_I == 8'h60 |=>
    PORT_ROUTE_HERE_O == {2{$past(REG_WDATA_I[0])}}) else $error("flag");
  reset_clear_a: assert property ($fell(SRST_I) |-> REG_RDATA_O == 0 &&
    PORT_ROUTE_HERE_O == 2'h0 && ASYNC_QH_ADDR_O[31:0] == 0 &&
    PERIODIC_LIST_ADDR_O[31:0] == 0) else $error("reset not clear");
  rdata_hold_a: assert property (!REG_RD_I |=>
    $stable(REG_RDATA_O)) else $error("read data moved");
endmodule

// >>> testbench.sv
/* ordered and random register traffic checked against a model
   assumes one-cycle strobes and read data registered for one cycle */
`timescale 1ns/1ns
module testbench;
  reg SYS_CLK_I = 1'b0;
  reg SRST_I = 1'b1;
  reg REG_WR_I = 1'b0;
  reg REG_RD_I = 1'b0;
  reg [7:0] REG_ADDR_I = 8'h00;
  reg [31:0] REG_WDATA_I = 32'h00000000;
  reg [31:0] CAPABILITY_PARAMETERS_I = 32'h00000000;
  reg [31:0] UPPER_SEGMENT_SELECTOR_I = 32'h00000000;
  wire [31:0] REG_RDATA_O;
  wire [63:0] PERIODIC_LIST_ADDR_O, ASYNC_QH_ADDR_O;
  wire [1:0] PORT_ROUTE_HERE_O, PORT_ROUTE_COMPANION_O;
  wire [31:0] up = CAPABILITY_PARAMETERS_I[0] ? UPPER_SEGMENT_SELECTOR_I :
    32'h00000000;
  reg [31:0] m [0:255];
  reg [31:0] last = 32'h00000000;
  reg [31:0] d;
  reg [7:0] a;
  reg f;
  reg [3:0] route;
  integer seed = 32'hF91AFF16, bad_count = 0, n_compared = 0, i, j;
  ehci_list_pointer_and_routing_regs DUT
  (
    .SYS_CLK_I(SYS_CLK_I),
    .SRST_I(SRST_I),
    .REG_ADDR_I(REG_ADDR_I),
    .REG_WR_I(REG_WR_I),
    .REG_RD_I(REG_RD_I),
    .REG_WDATA_I(REG_WDATA_I),
    .REG_RDATA_O(REG_RDATA_O),
    .CAPABILITY_PARAMETERS_I(CAPABILITY_PARAMETERS_I),
    .UPPER_SEGMENT_SELECTOR_I(UPPER_SEGMENT_SELECTOR_I),
    .PERIODIC_LIST_ADDR_O(PERIODIC_LIST_ADDR_O),
    .ASYNC_QH_ADDR_O(ASYNC_QH_ADDR_O),
    .PORT_ROUTE_HERE_O(PORT_ROUTE_HERE_O),
    .PORT_ROUTE_COMPANION_O(PORT_ROUTE_COMPANION_O)
  );
  initial forever #5 SYS_CLK_I = ~SYS_CLK_I;
  // implemented bits per offset; unmapped offsets keep nothing
  function [31:0] keep(input [7:0] k);
  begin
    keep = k == 8'h34 ? 32'hFFFFF000 : k == 8'h38 ? 32'hFFFFFFE0 :
      k == 8'h60 ? 32'h00000001 : 32'h00000000;
  end
  endfunction
  task chk(input [63:0] g, input [63:0] e);
  begin
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      bad_count = bad_count + 1;
      $display("unexpected %0t got %h want %h", $time, g, e);
    end
  end
  endtask
  task outs;
  begin
    f = m[8'h60][0];
    route = {{2{f}}, {2{~f}}};
    chk(PERIODIC_LIST_ADDR_O, {up, m[8'h34]});
    chk(ASYNC_QH_ADDR_O, {up, m[8'h38]});
    chk({PORT_ROUTE_HERE_O, PORT_ROUTE_COMPANION_O}, route);
    chk(REG_RDATA_O, last);
  end
  endtask
  // r raises the read strobe beside the write: the older value comes back
  task wr(input [7:0] ad, input [31:0] dd, input r);
  begin
    @(posedge SYS_CLK_I);
    REG_WR_I <= 1'b1;
    REG_RD_I <= r;
    REG_ADDR_I <= ad;
    REG_WDATA_I <= dd;
    CAPABILITY_PARAMETERS_I <= $random(seed);
    UPPER_SEGMENT_SELECTOR_I <= $random(seed);
    if (r)
      last = m[ad];
    m[ad] = dd & keep(ad);
    @(posedge SYS_CLK_I);
    REG_WR_I <= 1'b0;
    REG_RD_I <= 1'b0;
    #1 outs;
  end
  endtask
  task rd(input [7:0] ad);
  begin
    @(posedge SYS_CLK_I);
    REG_RD_I <= 1'b1;
    REG_ADDR_I <= ad;
    @(posedge SYS_CLK_I);
    REG_RD_I <= 1'b0;
    last = m[ad];
    #1 chk(REG_RDATA_O, last);
  end
  endtask
  task after_reset;
  begin
    for (j = 0; j < 256; j = j + 1)
      m[j] = 32'h00000000;
    last = 32'h00000000;
    #1 outs;
    for (j = 0; j < 4; j = j + 1)
      rd(j == 3 ? 8'h60 : 8'h34 + 8'h04 * j);
    $display("reset test done");
  end
  endtask
  task results;
  begin
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (4) @(posedge SYS_CLK_I);
    SRST_I <= 1'b0;
    after_reset;
    // pointers first, routing flag last, as host software sets them up
    wr(8'h34, $random(seed) & 32'hFFFFF000, 1'b0);
    wr(8'h38, 32'h00001000, 1'b0);
    wr(8'h60, 32'h00000001, 1'b0);
    $display("configure test done");
    // 3Ch sits in the loop as the unmapped offset
    for (i = 0; i < 60; i = i + 1)
    begin
      a = i % 4 == 3 ? 8'h60 : 8'h34 + 8'h04 * (i % 4);
      d = $random(seed);
      if (a != 8'h38 && a != 8'h3C)
        d = d & keep(a);
      wr(a, d, i % 8 == 5);
      rd(a);
    end
    $display("random test done");
    @(posedge SYS_CLK_I);
    SRST_I <= 1'b1;
    repeat (2) @(posedge SYS_CLK_I);
    SRST_I <= 1'b0;
    after_reset;
    results;
  end
endmodule
bind ehci_list_pointer_and_routing_regs list_regs_sva chk_i
(
  .SYS_CLK_I(SYS_CLK_I),
  .SRST_I(SRST_I),
  .REG_ADDR_I(REG_ADDR_I),
  .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I),
  .REG_WDATA_I(REG_WDATA_I),
  .REG_RDATA_O(REG_RDATA_O),
  .CAPABILITY_PARAMETERS_I(CAPABILITY_PARAMETERS_I),
  .UPPER_SEGMENT_SELECTOR_I(UPPER_SEGMENT_SELECTOR_I),
  .PERIODIC_LIST_ADDR_O(PERIODIC_LIST_ADDR_O),
  .ASYNC_QH_ADDR_O(ASYNC_QH_ADDR_O),
  .PORT_ROUTE_HERE_O(PORT_ROUTE_HERE_O),
  .PORT_ROUTE_COMPANION_O(PORT_ROUTE_COMPANION_O)
);
